// file: core/sfp_channel.sv
// Purpose: one channel of a 9-bit sync fifo with programmable flags
// Assumes: pin clocks and enables are sampled on sys_clk, edges detected here
// Notes:   words pass a staging fifo before the main array; flags are active low
`timescale 1ns/1ns
`include "sfp_map.svh"

// What this block does
// RULE1 - load pin low in reset selects load
// RULE2 - four 8-bit offset registers, writable and readable
// RULE3 - offset writes go empty low, high, full low, high
// RULE4 - after full high byte wrap to empty low
// RULE5 - load high resumes fifo, keeps sequence position
// RULE6 - offset reads follow the same sequence
// RULE7 - controller avoids simultaneous offset write and read
// RULE8 - almost empty low at n or fewer words
// RULE9 - almost empty high at n+1 or more
// RULE10 - almost full low at depth minus m
// RULE11 - almost full high when free exceeds m
// RULE12 - both offsets default to seven
// RULE13 - full flag low when full, blocks writes
// RULE14 - full flag changes only on write edges
// RULE15 - empty flag low when empty, blocks reads
// RULE16 - four flag outputs track occupancy
// RULE17 - single device ties read enable two low
// RULE18 - width expansion merges flags externally
// RULE19 - load pin high in reset gives enable
// RULE20 - data output holds last read when empty
// RULE21 - offset width equals pointer width, rest ignored
// RULE22 - reset restores defaults and sequence start
module sfp_channel
  import sfp_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   reset,
  input  wire logic                   write_clock_a,
  input  wire logic                   read_clock_a,
  input  wire logic [`SFP_DATA_W-1:0] data_in_a,
  input  wire logic                   primary_write_enable_a_n,
  input  wire logic                   second_write_enable_or_load_a,
  input  wire logic                   primary_read_enable_a_n,
  input  wire logic                   second_read_enable_a_n,
  output logic      [`SFP_DATA_W-1:0] data_out_a,
  output logic                        full_flag_a_n,
  output logic                        empty_flag_a_n,
  output logic                        almost_empty_flag_a_n,
  output logic                        almost_full_flag_a_n
);

  sfp_stream_if #(.W(`SFP_DATA_W)) fill_if ();   // write port into staging
  sfp_stream_if #(.W(`SFP_DATA_W)) drain_if ();  // staging into main array

  sfp_word_type  mem [`SFP_DEPTH_WORDS];  // main channel storage
  sfp_byte_type  offset_reg [`SFP_REG_COUNT];
  sfp_byte_type  next_offset_reg [`SFP_REG_COUNT];
  sfp_seq_type   seq;                     // offset access position
  sfp_seq_type   next_seq;
  logic          load_mode;               // pin acts as load control
  logic          next_load_mode;
  logic          wclk_prev;               // last sampled write clock
  logic          rclk_prev;               // last sampled read clock
  logic          wr_edge;                 // write clock rose
  logic          rd_edge;                 // read clock rose
  logic          load_active;             // load control held low
  logic          off_write;               // offset register write
  logic          off_read;                // offset register read
  logic          wr_accept;               // word enters the fifo
  logic          rd_accept;               // word leaves the fifo
  logic          drain;                   // staging word into array
  sfp_count_type occ;                     // words held, staging included
  sfp_count_type next_occ;
  sfp_count_type arr_cnt;                 // words in main array
  sfp_count_type next_arr_cnt;
  logic [`SFP_PTR_W-1:0] arr_wptr;
  logic [`SFP_PTR_W-1:0] arr_rptr;
  logic [`SFP_PTR_W-1:0] next_arr_wptr;
  logic [`SFP_PTR_W-1:0] next_arr_rptr;
  logic [`SFP_OFF_W-1:0] n_value;         // empty offset
  logic [`SFP_OFF_W-1:0] m_value;         // full offset
  logic [2*`SFP_REG_W-1:0] empty_wide;
  logic [2*`SFP_REG_W-1:0] full_wide;
  sfp_count_type full_threshold;          // depth minus m
  sfp_word_type  next_data_out;
  logic          next_full_n;
  logic          next_empty_n;
  logic          next_almost_empty_n;
  logic          next_almost_full_n;

  // clock edges and access decode
  assign wr_edge     = write_clock_a && !wclk_prev;
  assign rd_edge     = read_clock_a && !rclk_prev;
  assign load_active = load_mode && !second_write_enable_or_load_a;
  assign off_write   = wr_edge && load_active && !primary_write_enable_a_n;  // RULE3
  assign off_read    = rd_edge && load_active && !primary_read_enable_a_n
                       && !second_read_enable_a_n;                         // RULE6
  // in either mode a fifo write needs enable one low and the shared pin high
  assign wr_accept   = wr_edge && !primary_write_enable_a_n
                       && second_write_enable_or_load_a
                       && full_flag_a_n && fill_if.ready;                   // RULE13 RULE19
  assign rd_accept   = rd_edge && !load_active && !primary_read_enable_a_n
                       && !second_read_enable_a_n && empty_flag_a_n;        // RULE15

  // offset values, bits beyond the pointer width are ignored
  assign empty_wide     = {offset_reg[`SFP_IDX_EMPTY_HIGH], offset_reg[`SFP_IDX_EMPTY_LOW]};
  assign full_wide      = {offset_reg[`SFP_IDX_FULL_HIGH], offset_reg[`SFP_IDX_FULL_LOW]};
  assign n_value        = empty_wide[`SFP_OFF_W-1:0];                       // RULE21
  assign m_value        = full_wide[`SFP_OFF_W-1:0];                        // RULE21
  assign full_threshold = `SFP_DEPTH - {1'b0, m_value};

  // staging fifo on the write path
  assign fill_if.valid  = wr_accept;
  assign fill_if.data   = data_in_a;
  assign drain_if.ready = (arr_cnt != `SFP_DEPTH);
  assign drain          = drain_if.valid && drain_if.ready;

  sfp_stage_fifo #(
    .WIDTH (`SFP_DATA_W),
    .DEPTH (`SFP_STAGE_DEPTH)
  ) u_sfp_stage_fifo (
    .sys_clk (sys_clk),
    .reset   (reset),
    .push    (fill_if),
    .pop     (drain_if)
  );

  // mode capture, sampled on every cycle of reset
  always_comb
  begin
    next_load_mode = load_mode;
    if (reset)
      next_load_mode = !second_write_enable_or_load_a;                      // RULE1 RULE19
  end

  always_ff @(posedge sys_clk)
  begin
    load_mode <= next_load_mode;
  end

  // offset access sequence, shared by writes and reads
  always_comb
  begin
    next_seq = seq;
    if (off_write || off_read)
      next_seq = sfp_seq_step(seq);                                         // RULE4 RULE5
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      seq <= sfp_seq_empty_low;                                             // RULE22
    else
      seq <= next_seq;
  end

  // four offset bytes
  generate
    for (genvar i = 0; i < `SFP_REG_COUNT; i++)
    begin : g_offset
      localparam logic [1:0] IDX = 2'(i);
      localparam sfp_byte_type RST_VAL =
        ((IDX == `SFP_IDX_EMPTY_LOW) || (IDX == `SFP_IDX_FULL_LOW)) ?
        `SFP_RST_LOW_BYTE : `SFP_RST_HIGH_BYTE;

      // store on an offset write aimed at this byte
      always_comb
      begin
        next_offset_reg[i] = offset_reg[i];
        if (off_write && (sfp_seq_index(seq) == IDX))
          next_offset_reg[i] = data_in_a[`SFP_REG_W-1:0];                   // RULE2 RULE3
      end

      always_ff @(posedge sys_clk)
      begin
        if (reset)
          offset_reg[i] <= RST_VAL;                                         // RULE12 RULE22
        else
          offset_reg[i] <= next_offset_reg[i];
      end
    end
  endgenerate

  // occupancy and main array pointers
  always_comb
  begin
    next_occ      = occ;
    next_arr_cnt  = arr_cnt;
    next_arr_wptr = drain ? arr_wptr + `SFP_PTR_W'(1) : arr_wptr;
    next_arr_rptr = rd_accept ? arr_rptr + `SFP_PTR_W'(1) : arr_rptr;
    if (wr_accept && !rd_accept)
      next_occ = occ + `SFP_CNT_W'(1);
    else if (!wr_accept && rd_accept)
      next_occ = occ - `SFP_CNT_W'(1);
    if (drain && !rd_accept)
      next_arr_cnt = arr_cnt + `SFP_CNT_W'(1);
    else if (!drain && rd_accept)
      next_arr_cnt = arr_cnt - `SFP_CNT_W'(1);
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      occ      <= `SFP_RST_COUNT;
      arr_cnt  <= `SFP_RST_COUNT;
      arr_wptr <= `SFP_RST_PTR;
      arr_rptr <= `SFP_RST_PTR;
    end
    else
    begin
      occ      <= next_occ;
      arr_cnt  <= next_arr_cnt;
      arr_wptr <= next_arr_wptr;
      arr_rptr <= next_arr_rptr;
    end
  end

  // main array write
  always_ff @(posedge sys_clk)
  begin
    if (drain)
      mem[arr_wptr] <= drain_if.data;
  end

  // output word: fifo read or offset read-back, else hold
  always_comb
  begin
    next_data_out = data_out_a;                                             // RULE20
    if (rd_accept)
      next_data_out = mem[arr_rptr];
    else if (off_read)
      next_data_out = {1'b0, offset_reg[sfp_seq_index(seq)]};               // RULE6
  end

  // flags: write side on write edges, read side on read edges
  always_comb
  begin
    next_full_n         = full_flag_a_n;
    next_almost_full_n  = almost_full_flag_a_n;
    next_empty_n        = empty_flag_a_n;
    next_almost_empty_n = almost_empty_flag_a_n;
    if (wr_edge)
    begin
      next_full_n        = (next_occ != `SFP_DEPTH);                        // RULE13 RULE14
      next_almost_full_n = (next_occ < full_threshold);                     // RULE10 RULE11
    end
    if (rd_edge)
    begin
      next_empty_n        = (next_arr_cnt != `SFP_RST_COUNT);               // RULE15
      next_almost_empty_n = (next_arr_cnt > {1'b0, n_value});               // RULE8 RULE9
    end
  end

  // output and edge registers
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      wclk_prev             <= 1'b0;
      rclk_prev             <= 1'b0;
      data_out_a            <= `SFP_RST_DATA;
      full_flag_a_n         <= 1'b1;
      almost_full_flag_a_n  <= 1'b1;
      empty_flag_a_n        <= 1'b0;
      almost_empty_flag_a_n <= 1'b0;
    end
    else
    begin
      wclk_prev             <= write_clock_a;
      rclk_prev             <= read_clock_a;
      data_out_a            <= next_data_out;
      full_flag_a_n         <= next_full_n;                                 // RULE16
      almost_full_flag_a_n  <= next_almost_full_n;
      empty_flag_a_n        <= next_empty_n;
      almost_empty_flag_a_n <= next_almost_empty_n;
    end
  end

  chk_mode_capture_release : assert property (@(posedge sys_clk) // RULE1
    $fell(reset) |-> (load_mode == !$past(second_write_enable_or_load_a)))
    else $error("load mode not taken from pin at reset");

  chk_offset_store_order : assert property (@(posedge sys_clk) disable iff (reset) // RULE3
    (off_write && seq == sfp_seq_full_low) |=>
      (offset_reg[`SFP_IDX_FULL_LOW] == $past(data_in_a[`SFP_REG_W-1:0]))
      && (seq == sfp_seq_full_high))
    else $error("offset write went to wrong byte");

  chk_offset_seq_wrap : assert property (@(posedge sys_clk) disable iff (reset) // RULE4
    (off_write && seq == sfp_seq_full_high) |=> (seq == sfp_seq_empty_low))
    else $error("offset sequence did not wrap");

  chk_seq_kept_idle : assert property (@(posedge sys_clk) disable iff (reset) // RULE5
    !(off_write || off_read) |=> $stable(seq))
    else $error("offset position moved without access");

  chk_offset_read_back : assert property (@(posedge sys_clk) disable iff (reset) // RULE6
    (off_read && seq == sfp_seq_empty_high) |=>
      (data_out_a == {1'b0, $past(offset_reg[`SFP_IDX_EMPTY_HIGH])}))
    else $error("offset read-back wrong");

  chk_almost_empty_low : assert property (@(posedge sys_clk) disable iff (reset) // RULE8
    (rd_edge && (next_arr_cnt <= {1'b0, n_value})) |=> !almost_empty_flag_a_n)
    else $error("almost empty not low at n or fewer");

  chk_almost_empty_high : assert property (@(posedge sys_clk) disable iff (reset) // RULE9
    rd_edge ##1 (arr_cnt > {1'b0, $past(n_value)}) |-> almost_empty_flag_a_n)
    else $error("almost empty not high above n");

  chk_almost_full_level : assert property (@(posedge sys_clk) disable iff (reset) // RULE10
    wr_edge |=> (almost_full_flag_a_n == (occ < `SFP_DEPTH - {1'b0, $past(m_value)})))
    else $error("almost full flag wrong on write edge");

  chk_default_offsets : assert property (@(posedge sys_clk) // RULE12
    $fell(reset) |-> (n_value == `SFP_RST_LOW_BYTE) && (m_value == `SFP_RST_LOW_BYTE))
    else $error("offsets not seven after reset");

  chk_full_blocks_write : assert property (@(posedge sys_clk) disable iff (reset) // RULE13
    !full_flag_a_n |=> (occ <= $past(occ)))
    else $error("write taken while full");

  chk_full_write_clock : assert property (@(posedge sys_clk) disable iff (reset) // RULE14
    !wr_edge |=> $stable(full_flag_a_n))
    else $error("full flag moved without write edge");

  chk_empty_blocks_read : assert property (@(posedge sys_clk) disable iff (reset) // RULE15
    !empty_flag_a_n |=> (arr_cnt >= $past(arr_cnt)))
    else $error("read taken while empty");

  chk_hold_last_word : assert property (@(posedge sys_clk) disable iff (reset) // RULE20
    (!rd_accept && !off_read) |=> $stable(data_out_a))
    else $error("data output changed without read");

  cov_offset_wrap : cover property (@(posedge sys_clk) disable iff (reset)
    off_write && seq == sfp_seq_full_high);

  cov_full_reached : cover property (@(posedge sys_clk) disable iff (reset)
    !full_flag_a_n);

  cov_offset_read : cover property (@(posedge sys_clk) disable iff (reset)
    off_read);

  cov_empty_to_data : cover property (@(posedge sys_clk) disable iff (reset)
    !empty_flag_a_n ##1 empty_flag_a_n);

endmodule : sfp_channel

// file: shared/sfp_map.svh
// Purpose: constants for one channel of the programmable-flag sync fifo
// Assumes: included by the package and the channel module by bare name
// Notes:   widths, depths, field positions and reset values only
`ifndef SFP_MAP_SVH
`define SFP_MAP_SVH

// data path and storage
`define SFP_DATA_W        9
`define SFP_DEPTH_WORDS   256
`define SFP_DEPTH         9'h100
`define SFP_CNT_W         9
`define SFP_PTR_W         8
`define SFP_STAGE_DEPTH   16

// offset registers
`define SFP_REG_W         8
`define SFP_OFF_W         8
`define SFP_REG_COUNT     4
`define SFP_IDX_EMPTY_LOW  2'h0
`define SFP_IDX_EMPTY_HIGH 2'h1
`define SFP_IDX_FULL_LOW   2'h2
`define SFP_IDX_FULL_HIGH  2'h3

// reset values
`define SFP_RST_LOW_BYTE  8'h07
`define SFP_RST_HIGH_BYTE 8'h00
`define SFP_RST_DATA      9'h000
`define SFP_RST_COUNT     9'h000
`define SFP_RST_PTR       8'h00

`endif

// file: shared/sfp_pkg.sv
// Purpose: types and offset-sequence decoding for the sync fifo channel
// Assumes: sfp_map.svh gives the widths
// Notes:   the access sequence walks a gray code, one bit per step
`include "sfp_map.svh"

package sfp_pkg;

  // position in the offset register access sequence
  typedef enum logic [1:0]
  {
    sfp_seq_empty_low  = 2'h0,
    sfp_seq_empty_high = 2'h1,
    sfp_seq_full_low   = 2'h3,
    sfp_seq_full_high  = 2'h2
  } sfp_seq_type;

  typedef logic [`SFP_REG_W-1:0]  sfp_byte_type;
  typedef logic [`SFP_DATA_W-1:0] sfp_word_type;
  typedef logic [`SFP_CNT_W-1:0]  sfp_count_type;

  // register index selected by a sequence position
  function automatic logic [1:0] sfp_seq_index(input sfp_seq_type seq);
    logic [1:0] idx;
    idx = `SFP_IDX_EMPTY_LOW;
    unique case (seq)
      sfp_seq_empty_low:  idx = `SFP_IDX_EMPTY_LOW;
      sfp_seq_empty_high: idx = `SFP_IDX_EMPTY_HIGH;
      sfp_seq_full_low:   idx = `SFP_IDX_FULL_LOW;
      sfp_seq_full_high:  idx = `SFP_IDX_FULL_HIGH;
    endcase
    return idx;
  endfunction : sfp_seq_index

  // following position, wrapping after the full-offset high byte
  function automatic sfp_seq_type sfp_seq_step(input sfp_seq_type seq);
    sfp_seq_type nxt;
    nxt = sfp_seq_empty_low;
    unique case (seq)
      sfp_seq_empty_low:  nxt = sfp_seq_empty_high;
      sfp_seq_empty_high: nxt = sfp_seq_full_low;
      sfp_seq_full_low:   nxt = sfp_seq_full_high;
      sfp_seq_full_high:  nxt = sfp_seq_empty_low;
    endcase
    return nxt;
  endfunction : sfp_seq_step

endpackage : sfp_pkg

// file: shared/sfp_stream_if.sv
// Purpose: valid/ready word stream between the channel and its stage fifo
// Assumes: one clock, source holds data while valid and not ready
// Notes:   a word moves on a cycle with valid and ready both high
`timescale 1ns/1ns

interface sfp_stream_if #(parameter int W = 9);
  logic         valid;  // source offers a word
  logic         ready;  // sink takes it this cycle
  logic [W-1:0] data;   // offered word

  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface : sfp_stream_if

// file: core/sfp_stage_fifo.sv
// Purpose: small staging fifo on the write path of the channel
// Assumes: depth is a power of two
// Notes:   ready drops when full, valid drops when empty
`timescale 1ns/1ns

module sfp_stage_fifo
  import sfp_pkg::*;
#(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
)
(
  input wire logic      sys_clk,
  input wire logic      reset,
  sfp_stream_if.sink    push,
  sfp_stream_if.source  pop
);

  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL_COUNT = (PW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];  // staging storage
  logic [PW-1:0]    wr_ptr;       // next slot to fill
  logic [PW-1:0]    rd_ptr;       // oldest slot
  logic [PW:0]      count;        // words held
  logic [PW-1:0]    next_wr_ptr;
  logic [PW-1:0]    next_rd_ptr;
  logic [PW:0]      next_count;
  logic             push_fire;    // word taken in
  logic             pop_fire;     // word handed on

  // honest full and empty
  assign push.ready = (count != FULL_COUNT);
  assign pop.valid  = (count != '0);
  assign pop.data   = mem[rd_ptr];
  assign push_fire  = push.valid && push.ready;
  assign pop_fire   = pop.valid && pop.ready;

  // pointer and level next values
  always_comb
  begin
    next_wr_ptr = push_fire ? wr_ptr + PW'(1) : wr_ptr;
    next_rd_ptr = pop_fire ? rd_ptr + PW'(1) : rd_ptr;
    next_count  = count;
    if (push_fire && !pop_fire)
      next_count = count + (PW+1)'(1);
    else if (!push_fire && pop_fire)
      next_count = count - (PW+1)'(1);
  end

  // register pointers and level
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // storage write
  always_ff @(posedge sys_clk)
  begin
    if (push_fire)
      mem[wr_ptr] <= push.data;
  end

  chk_stage_no_overfill : assert property (@(posedge sys_clk) disable iff (reset)
    count <= FULL_COUNT)
    else $error("stage fifo ready while full");

  chk_stage_level_track : assert property (@(posedge sys_clk) disable iff (reset)
    (push_fire && !pop_fire) |=> (count == $past(count) + (PW+1)'(1)))
    else $error("stage fifo level missed a push");

  cov_stage_fills : cover property (@(posedge sys_clk) disable iff (reset)
    count == FULL_COUNT);

endmodule : sfp_stage_fifo

// file: testbench/sfp_port_agent.sv
// Purpose: pin-side agent that makes the write and read clock pulses
// Assumes: one request pulse per transfer, at least four cycles apart
// Notes:   each clock is high for one sys_clk cycle, then stands low
`timescale 1ns/1ns

module sfp_port_agent
(
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic wr_go,
  input  wire logic rd_go,
  output logic      write_clock_a,
  output logic      read_clock_a
);
  logic next_write_clock_a; // next write pin level
  logic next_read_clock_a;  // next read pin level

  // a request gives one high sample, clocks rest low, none in reset
  always_comb
  begin
    next_write_clock_a = wr_go & ~reset;
    // read pulse never shares a cycle with a write pulse
    next_read_clock_a  = rd_go & ~reset & ~wr_go;
  end

  // register the pin clocks
  always_ff @(posedge sys_clk)
  begin
    write_clock_a <= next_write_clock_a;
    read_clock_a  <= next_read_clock_a;
  end
endmodule : sfp_port_agent

// file: testbench/sync_fifo_programmable_flags_tb_top.sv
// Purpose: self-checking bench for one programmable-flag fifo channel
// Assumes: pin clocks come from sfp_port_agent
// Notes:   flag_word packs full, almost full, almost empty, empty
`timescale 1ns/1ns

module sync_fifo_programmable_flags_tb_top;
  import sfp_pkg::*;

  logic         sys_clk;
  logic         reset;
  logic         write_clock_a;
  logic         read_clock_a;
  sfp_word_type data_in_a;
  logic         primary_write_enable_a_n;
  logic         second_write_enable_or_load_a;
  logic         primary_read_enable_a_n;
  logic         second_read_enable_a_n;
  sfp_word_type data_out_a;
  logic         full_flag_a_n;
  logic         empty_flag_a_n;
  logic         almost_empty_flag_a_n;
  logic         almost_full_flag_a_n;
  logic         wr_go;       // ask agent for a write clock pulse
  logic         rd_go;       // ask agent for a read clock pulse
  sfp_word_type flag_word;   // all four flags in one word
  int           mismatches;
  int           checks_done;
  int           cycles;
  sfp_byte_type dflt [4] = '{8'h07, 8'h00, 8'h07, 8'h00};
  sfp_byte_type prog [5] = '{8'h03, 8'haa, 8'h05, 8'hbb, 8'h04};

  assign flag_word = {5'h00, full_flag_a_n, almost_full_flag_a_n,
                      almost_empty_flag_a_n, empty_flag_a_n};

  sfp_channel u_sfp_channel (.sys_clk, .reset, .write_clock_a, .read_clock_a,
    .data_in_a, .primary_write_enable_a_n, .second_write_enable_or_load_a,
    .primary_read_enable_a_n, .second_read_enable_a_n, .data_out_a,
    .full_flag_a_n, .empty_flag_a_n, .almost_empty_flag_a_n, .almost_full_flag_a_n);

  sfp_port_agent u_sfp_port_agent (.sys_clk, .reset, .wr_go, .rd_go,
    .write_clock_a, .read_clock_a);

  // free running system clock, 20 ns
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // compare and count
  task automatic check(input sfp_word_type seen, input sfp_word_type exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // verdict and end of run
  task automatic complete_run;
    if (mismatches == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  // reset with the shared pin held at ld
  task automatic restart(input logic ld);
    @(posedge sys_clk);
    reset <= 1'b1;
    second_write_enable_or_load_a <= ld;
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
  endtask : restart

  // one write clock pulse with data and enables held around it
  task automatic pulse_wr(input sfp_word_type d, input logic en_n, input logic ld);
    @(posedge sys_clk);
    data_in_a <= d;
    primary_write_enable_a_n <= en_n;
    second_write_enable_or_load_a <= ld;
    wr_go <= 1'b1;
    @(posedge sys_clk);
    wr_go <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask : pulse_wr

  // one read clock pulse with enables and shared pin held around it
  task automatic pulse_rd(input logic r1_n, input logic r2_n, input logic ld);
    @(posedge sys_clk);
    primary_read_enable_a_n <= r1_n;
    second_read_enable_a_n <= r2_n;
    second_write_enable_or_load_a <= ld;
    rd_go <= 1'b1;
    @(posedge sys_clk);
    rd_go <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask : pulse_rd

  // hang guard, about two and a half times the expected run
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      mismatches++;
      complete_run();
    end
  end

  // main sequence
  initial
  begin
    reset = 1'b1;
    data_in_a = 9'h000;
    primary_write_enable_a_n = 1'b1;
    second_write_enable_or_load_a = 1'b0;
    primary_read_enable_a_n = 1'b1;
    second_read_enable_a_n = 1'b1;
    wr_go = 1'b0;
    rd_go = 1'b0;
    mismatches = 0;
    checks_done = 0;
    cycles = 0;
    restart(1'b0);
    check(flag_word, 9'h00c);
    // default offsets read back in order
    for (int i = 0; i < 4; i++)
    begin
      pulse_rd(1'b0, 1'b0, 1'b0);
      check(data_out_a, {1'b0, dflt[i]});
    end
    // five writes wrap back to the empty offset low byte
    for (int i = 0; i < 5; i++)
      pulse_wr({1'b0, prog[i]}, 1'b0, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      pulse_rd(1'b0, 1'b0, 1'b0);
      check(data_out_a, {1'b0, prog[i + 1]});
    end
    // fill with n = 4 and m = 5
    for (int i = 0; i < 256; i++)
    begin
      pulse_wr(sfp_word_type'(i * 2 + 1), 1'b0, 1'b1);
      if (i == 3 || i == 4)
        pulse_rd(1'b1, 1'b0, 1'b1);
      if (i == 3)
        check(flag_word, 9'h00d);
      if (i == 4)
        check(flag_word, 9'h00f);
      if (i == 249)
        check(flag_word, 9'h00f);
      if (i == 250 || i == 254)
        check(flag_word, 9'h00b);
      if (i == 255)
        check(flag_word, 9'h003);
    end
    // write while full is dropped
    pulse_wr(9'h0ff, 1'b0, 1'b1);
    for (int i = 0; i < 256; i++)
    begin
      pulse_rd(1'b0, 1'b0, 1'b1);
      check(data_out_a, sfp_word_type'(i * 2 + 1));
      if (i == 0)
      begin
        check(flag_word, 9'h003);
        pulse_wr(9'h000, 1'b1, 1'b1);
        check(flag_word, 9'h00b);
      end
    end
    check(flag_word, 9'h008);
    pulse_rd(1'b0, 1'b0, 1'b1);
    check(data_out_a, 9'h1ff);
    // sequence position kept across normal operation
    pulse_rd(1'b0, 1'b0, 1'b0);
    check(data_out_a, 9'h0aa);
    // second enable mode: pin low blocks, pin high writes
    restart(1'b1);
    check(flag_word, 9'h00c);
    pulse_wr(9'h055, 1'b0, 1'b0);
    pulse_wr(9'h0aa, 1'b0, 1'b1);
    // empty flag rises on this read edge only, so nothing is read yet
    pulse_rd(1'b0, 1'b0, 1'b0);
    check(data_out_a, 9'h000);
    pulse_rd(1'b0, 1'b0, 1'b0);
    check(data_out_a, 9'h0aa);
    pulse_rd(1'b0, 1'b0, 1'b0);
    check(flag_word, 9'h00c);
    complete_run();
  end
endmodule : sync_fifo_programmable_flags_tb_top
